// ### hdl/ledind_pkg.sv
// Purpose: shared constants and types for the indicator lamp logic.
// Assumes: 250 MHz system clock, 32-bit APB register access.
// Notes: one package serves the single design file and the bench.
package ledind_pkg;

    // ------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------
    localparam int NUM_SRC = 5;
    localparam int CLK_MHZ = 250;
    localparam int FLASH_HALF_MS = 500;
    localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_MHZ * 1000;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] CFG_OFFS = 12'h000;
    localparam logic [11:0] STAT_OFFS = 12'h004;

    // configuration word fields
    localparam int CFG_INV_LSB = 0;
    localparam int CFG_LATCH_BIT = 5;
    localparam int CFG_ACT_LSB = 8;
    localparam int CFG_INACT_LSB = 12;

    // status word fields
    localparam int ST_SRC_LSB = 0;
    localparam int ST_COMB_BIT = 5;
    localparam int ST_HELD_BIT = 6;
    localparam int ST_RED_BIT = 7;
    localparam int ST_GREEN_BIT = 8;

    // ------------------------------------------------------------
    // colour settings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        LEDIND_DARK = 3'b000,
        LEDIND_GREEN = 3'b001,
        LEDIND_RED = 3'b010,
        LEDIND_RED_FLASH = 3'b011,
        LEDIND_GREEN_FLASH = 3'b100
    } ledind_color_t;

    typedef struct packed {
        ledind_color_t inact_color;
        ledind_color_t act_color;
        logic latch_en;
        logic [NUM_SRC-1:0] invert;
    } ledind_cfg_t;

    localparam ledind_cfg_t CFG_RESET = '{
        inact_color: LEDIND_DARK,
        act_color: LEDIND_RED,
        latch_en: 1'b0,
        invert: 5'h00
    };

    // lamp drive pair
    typedef struct packed {
        logic red;
        logic green;
    } ledind_lamp_t;

endpackage : ledind_pkg

// ### hdl/ledind_top.sv
// Purpose: one front-panel indicator: source combine, latch, colour and flash.
// Assumes: sources and acknowledge are synchronous to clk_i.
// Notes: configuration and status reachable over a zero-wait APB slave.
//
// How it works
// - each of the sources may be inverted on its own; inversion off by default
// - lamp state follows the OR of all sources after their inversion
// - true state shows active colour: green, red, flashing red/green; red default
// - false state shows inactive colour, any of those or dark; dark default
// - optional latch, off by default, holds a pickup after sources fall
// - acknowledge clears the held pickup only once no source is still present
// - acknowledge is ignored entirely while latching is off
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps

module ledind_top
    import ledind_pkg::*;
#(
    parameter int FLASH_HALF = ledind_pkg::FLASH_HALF_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // indicator sources and acknowledge
    input wire logic [ledind_pkg::NUM_SRC-1:0] src_i,
    input wire logic ack_i,
    // lamp drive
    output ledind_pkg::ledind_lamp_t lamp_o
);
    import ledind_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // unknown codes behave as dark so a bad write cannot light the lamp
    function automatic ledind_lamp_t color_drive(input logic [2:0] code,
                                                 input logic phase);
        ledind_lamp_t l;
        l = '0;
        case (code)
            LEDIND_GREEN: begin
                l.green = 1'b1;
            end
            LEDIND_RED: begin
                l.red = 1'b1;
            end
            LEDIND_RED_FLASH: begin
                l.red = phase;
            end
            LEDIND_GREEN_FLASH: begin
                l.green = phase;
            end
            default: begin
                l = '0;
            end
        endcase
        return l;
    endfunction : color_drive

    // ------------------------------------------------------------
    // register images
    // ------------------------------------------------------------
    // one place defines each read layout from the package field constants; the bench checks it with its own literals
    function automatic logic [31:0] cfg_word(input ledind_cfg_t c);
        logic [31:0] w;
        w = 32'h00000000;
        w[CFG_INV_LSB +: NUM_SRC] = c.invert;
        w[CFG_LATCH_BIT] = c.latch_en;
        w[CFG_ACT_LSB +: 3] = c.act_color;
        w[CFG_INACT_LSB +: 3] = c.inact_color;
        return w;
    endfunction : cfg_word

    // unused status bits read as zero so later fields can be added safely
    function automatic logic [31:0] stat_word(input logic [NUM_SRC-1:0] s,
                                              input logic comb,
                                              input logic held,
                                              input ledind_lamp_t lamp);
        logic [31:0] w;
        w = 32'h00000000;
        w[ST_SRC_LSB +: NUM_SRC] = s;
        w[ST_COMB_BIT] = comb;
        w[ST_HELD_BIT] = held;
        w[ST_RED_BIT] = lamp.red;
        w[ST_GREEN_BIT] = lamp.green;
        return w;
    endfunction : stat_word

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    ledind_cfg_t cfg_reg;
    logic held_reg;
    logic flash_phase_reg;
    ledind_lamp_t lamp_reg;
    logic [NUM_SRC-1:0] src_eff;
    logic combined;
    logic shown_active;
    logic acc_phase;
    logic addr_hit_cfg;
    logic addr_hit_stat;

    assign acc_phase = psel_i & penable_i;
    assign addr_hit_cfg = (paddr_i == CFG_OFFS);
    assign addr_hit_stat = (paddr_i == STAT_OFFS);
    // zero wait states: every access completes in its first access cycle
    assign pready_o = 1'b1;
    assign pslverr_o = acc_phase & ~(addr_hit_cfg | addr_hit_stat);
    // reads are loaded in the setup cycle, so the status image is one cycle
    // older than the access phase; software polls, so the lag is harmless
    // writes to the status offset are dropped without an error response

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cfg_reg <= CFG_RESET;
        end else if (acc_phase && pwrite_i && addr_hit_cfg) begin
            cfg_reg.invert <= pwdata_i[CFG_INV_LSB +: NUM_SRC];
            cfg_reg.latch_en <= pwdata_i[CFG_LATCH_BIT];
            cfg_reg.act_color <= ledind_color_t'(pwdata_i[CFG_ACT_LSB +: 3]);
            cfg_reg.inact_color <= ledind_color_t'(pwdata_i[CFG_INACT_LSB +: 3]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            prdata_o <= 32'h00000000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            if (addr_hit_cfg) begin
                prdata_o <= cfg_word(cfg_reg);
            end else if (addr_hit_stat) begin
                prdata_o <= stat_word(src_i, combined, held_reg, lamp_reg);
            end else begin
                prdata_o <= 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------
    // source combine
    // ------------------------------------------------------------
    // inversion is an xor so a cleared invert bit passes the source unchanged
    assign src_eff = src_i ^ cfg_reg.invert;
    assign combined = |src_eff;

    // ------------------------------------------------------------
    // latch and acknowledge
    // ------------------------------------------------------------
    // a live pickup always wins over an acknowledge in the same cycle
    // the held flag is cleared while latching is off so that turning the
    // option on later cannot show a stale pickup
    // acknowledge is a level: holding it high clears each new hold as soon
    // as its sources fall
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            held_reg <= 1'b0;
        end else if (!cfg_reg.latch_en) begin
            held_reg <= 1'b0;
        end else if (combined) begin
            held_reg <= 1'b1;
        end else if (ack_i) begin
            held_reg <= 1'b0;
        end
    end

    assign shown_active = combined | held_reg;

    // ------------------------------------------------------------
    // flash divider
    // ------------------------------------------------------------
    // the divider runs free, so all lamps built from this block flash in step
    // when they share a reset; the cost is a 32-bit counter per lamp
    // the half period must be at least one cycle
    logic [31:0] flash_cnt_reg;
    logic flash_tick;

    assign flash_tick = (flash_cnt_reg == 32'(FLASH_HALF - 1));

    always_ff @(posedge clk_i) begin
        if (!rstn_i || flash_tick) begin
            flash_cnt_reg <= 32'h00000000;
        end else begin
            flash_cnt_reg <= flash_cnt_reg + 32'h00000001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            flash_phase_reg <= 1'b1;
        end else if (flash_tick) begin
            flash_phase_reg <= ~flash_phase_reg;
        end
    end

    // ------------------------------------------------------------
    // colour output
    // ------------------------------------------------------------
    // the lamp is registered: one cycle from a source change to the pin,
    // and both colours come from one flip-flop pair so they never glitch
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            lamp_reg <= '0;
        end else if (shown_active) begin
            lamp_reg <= color_drive(cfg_reg.act_color, flash_phase_reg);
        end else begin
            lamp_reg <= color_drive(cfg_reg.inact_color, flash_phase_reg);
        end
    end

    assign lamp_o = lamp_reg;

endmodule : ledind_top

// ### test/ledind_chk.sv
// Purpose: port-level checks of one indicator lamp
// Assumes: zero-wait apb, cfg word at 0x000
// Notes: keeps its own shadow of the config word
`timescale 1ns/100ps
module ledind_chk
    import ledind_pkg::*;
#(
    parameter int FLASH_HALF = 8
) (
    // clock, reset, apb
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // lamp side
    input wire logic [NUM_SRC-1:0] src_i,
    input wire logic ack_i,
    input wire ledind_lamp_t lamp_o
);
    logic [14:0] cfg_reg;
    logic comb;
    logic lat;
    logic acc;
    assign comb = |(src_i ^ cfg_reg[4:0]);
    assign lat = cfg_reg[5];
    assign acc = psel_i && penable_i;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            cfg_reg <= 15'h0200;
        end else if (acc && pwrite_i && paddr_i == 12'h000) begin
            cfg_reg <= pwdata_i[14:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    sequence s_pick;
        lat && comb && cfg_reg[10:8] == 3'h2;
    endsequence
    a_zero_wait: assert property (acc |-> pready_o) else $error("no ready");
    a_bad_addr: assert property (acc && paddr_i != 12'h000 && paddr_i != 12'h004 |-> pslverr_o)
        else $error("no error on unmapped");
    a_good_addr: assert property (acc && paddr_i == 12'h000 |-> !pslverr_o) else $error("err");
    a_steady_red: assert property (!lat && comb && cfg_reg[10:8] == 3'h2 |=> lamp_o == 2'h2)
        else $error("active red wrong");
    a_dark_idle: assert property (!lat && !comb && cfg_reg[14:12] == 3'h0 |=> lamp_o == 2'h0)
        else $error("inactive dark wrong");
    a_latch_hold: assert property (s_pick ##1 (lat && !comb && !ack_i) |=> lamp_o == 2'h2)
        else $error("hold lost");
    a_ack_clear: assert property ((lat && !comb && ack_i) ##1 (lat && !comb
        && cfg_reg[14:12] == 3'h0) |=> lamp_o == 2'h0) else $error("ack failed");
    a_flash_hue: assert property (!lat && comb && cfg_reg[10:8] == 3'h3 |=> !lamp_o.green)
        else $error("flash hue wrong");
endmodule : ledind_chk

// ### test/ledind_top_test.sv
// Purpose: self-checking bench for the indicator lamp
// Assumes: FLASH_HALF shortened to 8 cycles
// Notes: table of steady cases, then flash and latch by hand
`timescale 1ns/100ps
module ledind_top_test;
    import ledind_pkg::*;
    typedef struct packed {
        logic [15:0] cfg;
        logic [4:0] src;
        logic [1:0] lamp;
    } ledind_row_t;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [4:0] src_i = 5'h00;
    logic ack_i = 1'b0;
    ledind_lamp_t lamp_o;
    logic [31:0] rd;
    logic [31:0] n;
    logic er;
    logic prev;
    int bad_count = 0;
    int n_checks = 0;
    ledind_row_t rows [8] = '{'{16'h0200, 5'h00, 2'h0}, '{16'h0200, 5'h01, 2'h2},
        '{16'h0200, 5'h10, 2'h2}, '{16'h0201, 5'h00, 2'h2}, '{16'h0201, 5'h01, 2'h0},
        '{16'h0100, 5'h08, 2'h1}, '{16'h1200, 5'h00, 2'h1}, '{16'h2200, 5'h00, 2'h2}};
    always #2 clk_i = ~clk_i;
    ledind_top #(.FLASH_HALF(8)) i_dut (.*);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task conclude;
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            conclude();
        end
    endtask : apb
    initial begin
        repeat (5) @(posedge clk_i);
        chk({30'h0, lamp_o}, 32'h0);
        chk(prdata_o, 32'h0);
        rstn_i <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000_0200);
        ack_i <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, 12'h000, {16'h0, rows[i].cfg});
            src_i <= rows[i].src;
            repeat (2) @(posedge clk_i);
            #1 chk({30'h0, lamp_o}, {30'h0, rows[i].lamp});
        end
        $display("row table done");
        apb(1'b1, 12'h004, 32'hFFFF_FFFF);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0000_0080);
        apb(1'b0, 12'h008, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("apb done");
        ack_i <= 1'b0;
        for (int c = 3; c < 5; c++) begin
            apb(1'b1, 12'h000, {21'h0, 3'(c), 8'h00});
            src_i <= 5'h01;
            repeat (3) @(posedge clk_i);
            #1 prev = (c == 3) ? lamp_o.red : lamp_o.green;
            n = 0;
            repeat (32) begin
                @(posedge clk_i);
                #1 n = n + (((c == 3) ? lamp_o.red : lamp_o.green) !== prev);
                prev = (c == 3) ? lamp_o.red : lamp_o.green;
            end
            chk(n, 32'h4);
        end
        $display("flash done");
        apb(1'b1, 12'h000, 32'h0000_0220);
        ack_i <= 1'b1;
        @(posedge clk_i);
        src_i <= 5'h00;
        ack_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        #1 chk({30'h0, lamp_o}, 32'h2);
        @(posedge clk_i);
        ack_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 chk({30'h0, lamp_o}, 32'h0);
        $display("latch done");
        @(posedge clk_i);
        ack_i <= 1'b0;
        src_i <= 5'h01;
        @(posedge clk_i);
        @(posedge clk_i);
        src_i <= 5'h00;
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 chk({30'h0, lamp_o}, 32'h0);
        @(posedge clk_i);
        rstn_i <= 1'b1;
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0000_0200);
        $display("reset done");
        conclude();
    end
endmodule : ledind_top_test
bind ledind_top ledind_chk #(.FLASH_HALF(FLASH_HALF)) u_chk (.*);
